// ===== dma_pkg.sv
// Shared constants and types for the serial byte-mode DMA link
// Functional notes
// [R01] Serial side drives ready line toward DMA
// [R02] Ready active low, one byte per assertion
// [R03] Ready after character; request two periods later
// [R04] CPU ends cycle in 1-5, grants after 1
// [R05] Receive: I/O read +4, memory write +4
// [R06] Receive: request drops +2, write ends +1
// [R07] Receive: grant withdrawn 1 after write ends
// [R08] Transmit ready 5-6 after last bit
// [R09] Transmit: memory read +4, I/O write +3
// [R10] Transmit: request drops +3, write ends +1
// [R11] Transmit: grant withdrawn 1 after write ends
// [R12] After each byte, wait for fresh ready
package dma_pkg;
  // System clock
  localparam int CLK_PERIOD_NS = 50;
  // Widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 4;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [CNT_W-1:0]  cnt_t;

  // Delays, in clock periods
  localparam int RX_READY_DLY_CLK  = 10;  // Within 10-13 after last bit
  localparam int TX_READY_DLY_CLK  = 5;   // Within 5-6 after last bit
  localparam int REQ_DLY_CLK       = 2;   // Ready to bus request
  localparam int CPU_END_MIN_CLK   = 1;   // Machine cycle end, least
  localparam int CPU_END_MAX_CLK   = 5;   // Machine cycle end, most
  localparam int GRANT_DLY_CLK     = 1;   // Cycle end to grant
  localparam int ACK_DLY_CLK       = 4;   // Grant to first cycle
  localparam int RX_FIRST_CLK      = 4;   // I/O read to memory write
  localparam int TX_FIRST_CLK      = 3;   // Memory read to I/O write
  localparam int RX_DROP_CLK       = 2;   // Memory write to request drop
  localparam int TX_DROP_CLK       = 3;   // I/O write to request drop
  localparam int TAIL_CLK          = 1;   // Request drop to write end

  // Counter end values; an observed event costs one sampling edge
  localparam cnt_t REQ_END      = cnt_t'(REQ_DLY_CLK - 2);
  localparam cnt_t ACK_END      = cnt_t'(ACK_DLY_CLK - 2);
  localparam cnt_t RX_FIRST_END = cnt_t'(RX_FIRST_CLK - 1);
  localparam cnt_t TX_FIRST_END = cnt_t'(TX_FIRST_CLK - 1);
  localparam cnt_t RX_DROP_END  = cnt_t'(RX_DROP_CLK - 1);
  localparam cnt_t TX_DROP_END  = cnt_t'(TX_DROP_CLK - 1);
  localparam cnt_t TAIL_END     = cnt_t'(TAIL_CLK - 1);
  localparam cnt_t RX_RDY_END   = cnt_t'(RX_READY_DLY_CLK - 1);
  localparam cnt_t TX_RDY_END   = cnt_t'(TX_READY_DLY_CLK - 1);
  localparam cnt_t CPU_MIN_END  = cnt_t'(CPU_END_MIN_CLK - 1);
  localparam cnt_t CPU_MAX_END  = cnt_t'(CPU_END_MAX_CLK - 1);
  localparam cnt_t CNT_ZERO     = 4'h0;
  localparam cnt_t CNT_ONE      = 4'h1;

  // Reset values and address step
  localparam addr_t ADDR_ZERO = 16'h0000;
  localparam addr_t ADDR_ONE  = 16'h0001;
  localparam data_t DATA_ZERO = 8'h00;
endpackage

// ===== dma_link_if.sv
// Link between the DMA end and the CPU/serial-controller end
interface dma_link_if;
  import dma_pkg::*;
  logic  readyN;           // Serial controller wants a byte moved, active low
  logic  busRequestLineN;  // DMA asks for the bus, active low
  logic  busGrantLineN;    // CPU has released the bus, active low
  logic  memRd;            // DMA memory read cycle
  logic  memWr;            // DMA memory write cycle
  logic  ioRd;             // DMA read of the serial controller
  logic  ioWr;             // DMA write to the serial controller
  addr_t memAddr;          // Memory address from the DMA
  data_t dmaData;          // Data driven by the DMA on writes
  data_t hostData;         // Data returned on DMA reads

  modport dma (
    input  readyN, busGrantLineN, hostData,
    output busRequestLineN, memRd, memWr, ioRd, ioWr, memAddr, dmaData
  );
  modport host (
    output readyN, busGrantLineN, hostData,
    input  busRequestLineN, memRd, memWr, ioRd, ioWr, memAddr, dmaData
  );
endinterface

// ===== dma_byte_engine.sv
// DMA end: byte-mode transfer sequencer toward memory and serial controller
module dma_byte_engine (
  input  wire logic            core_clk,    // System clock
  input  wire logic            sys_rst,     // Synchronous reset, active high
  dma_link_if.dma              link,        // Bus and ready lines
  input  wire logic            enable,      // Allow transfers
  input  wire logic            txMode,      // 1 transmit, 0 receive
  input  wire logic            loadBlock,   // Pulse: load address and length
  input  wire dma_pkg::addr_t  startAddr,   // Block start address
  input  wire dma_pkg::addr_t  blockLen,    // Block length in bytes
  output logic                 byteDone,    // Pulse: one byte moved
  output logic                 blockDone,   // Level: block length used up
  output dma_pkg::addr_t       bytesLeft,   // Bytes still to move
  output dma_pkg::data_t       lastByte,    // Last byte carried
  output logic                 busy         // Transfer in progress
);
  import dma_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_REQ_DLY  = 4'h1,
    ST_WAIT_ACK = 4'h2,
    ST_ACK_DLY  = 4'h3,
    ST_FIRST    = 4'h4,
    ST_SECOND   = 4'h5,
    ST_TAIL     = 4'h6,
    ST_RELEASE  = 4'h7,
    ST_REARM    = 4'h8
  } state_e;

  state_e state_r;
  state_e state_nxt;
  cnt_t   cnt_r;
  cnt_t   cnt_nxt;
  logic   dirTx_r;
  logic   busReqN_r;
  logic   memRd_r;
  logic   memWr_r;
  logic   ioRd_r;
  logic   ioWr_r;
  addr_t  addr_r;
  addr_t  left_r;
  data_t  data_r;
  logic   byteDone_r;
  cnt_t   firstEnd;
  cnt_t   dropEnd;
  logic   cntHit;

  // Direction-dependent spacing of the two bus cycles
  always_comb begin
    firstEnd = dirTx_r ? TX_FIRST_END : RX_FIRST_END;  // R05 R09
    dropEnd  = dirTx_r ? TX_DROP_END : RX_DROP_END;    // R06 R10
  end

  // Counter end for the current state
  always_comb begin
    case (state_r)
      ST_REQ_DLY: cntHit = (cnt_r == REQ_END);
      ST_ACK_DLY: cntHit = (cnt_r == ACK_END);
      ST_FIRST:   cntHit = (cnt_r == firstEnd);
      ST_SECOND:  cntHit = (cnt_r == dropEnd);
      ST_TAIL:    cntHit = (cnt_r == TAIL_END);
      default:    cntHit = 1'b0;
    endcase
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // Ready seen low: one byte to move
        if (enable && !link.readyN && (left_r != ADDR_ZERO)) begin
          state_nxt = ST_REQ_DLY;  // R02 R03
        end
      end
      ST_REQ_DLY: begin
        if (cntHit) begin
          state_nxt = ST_WAIT_ACK;  // R03
        end
      end
      ST_WAIT_ACK: begin
        if (!link.busGrantLineN) begin
          state_nxt = ST_ACK_DLY;
        end
      end
      ST_ACK_DLY: begin
        if (cntHit) begin
          state_nxt = ST_FIRST;  // R05 R09
        end
      end
      ST_FIRST: begin
        if (cntHit) begin
          state_nxt = ST_SECOND;  // R05 R09
        end
      end
      ST_SECOND: begin
        if (cntHit) begin
          state_nxt = ST_TAIL;  // R06 R10
        end
      end
      ST_TAIL: begin
        if (cntHit) begin
          state_nxt = ST_RELEASE;  // R06 R10
        end
      end
      ST_RELEASE: begin
        // Bus goes back to the CPU before anything else
        if (link.busGrantLineN) begin
          state_nxt = ST_REARM;  // R12
        end
      end
      ST_REARM: begin
        // Byte mode: a fresh ready assertion is needed
        if (link.readyN) begin
          state_nxt = ST_IDLE;  // R02 R12
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Cycle counter restarts on every state change
  always_comb begin
    if (state_nxt != state_r) begin
      cnt_nxt = CNT_ZERO;
    end else begin
      cnt_nxt = cnt_r + CNT_ONE;
    end
  end

  // State and counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Direction frozen at the start of each byte
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dirTx_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      dirTx_r <= txMode;
    end
  end

  // Bus request line
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busReqN_r <= 1'b1;
    end else if (state_r == ST_REQ_DLY && cntHit) begin
      busReqN_r <= 1'b0;  // R03
    end else if (state_r == ST_SECOND && cntHit) begin
      busReqN_r <= 1'b1;  // R06 R10
    end
  end

  // Bus cycle strobes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      memRd_r <= 1'b0;
      memWr_r <= 1'b0;
      ioRd_r  <= 1'b0;
      ioWr_r  <= 1'b0;
    end else if (state_r == ST_ACK_DLY && cntHit) begin
      ioRd_r  <= !dirTx_r;  // R05
      memRd_r <= dirTx_r;   // R09
    end else if (state_r == ST_FIRST && cntHit) begin
      ioRd_r  <= 1'b0;
      memRd_r <= 1'b0;
      memWr_r <= !dirTx_r;  // R05
      ioWr_r  <= dirTx_r;   // R09
    end else if (state_r == ST_TAIL && cntHit) begin
      memWr_r <= 1'b0;  // R06
      ioWr_r  <= 1'b0;  // R10
    end
  end

  // Byte latched as the read cycle ends
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      data_r <= DATA_ZERO;
    end else if (state_r == ST_FIRST && cntHit) begin
      data_r <= link.hostData;
    end
  end

  // Address and remaining count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_r <= ADDR_ZERO;
      left_r <= ADDR_ZERO;
    end else if (loadBlock && state_r == ST_IDLE) begin
      addr_r <= startAddr;
      left_r <= blockLen;
    end else if (state_r == ST_TAIL && cntHit) begin
      addr_r <= addr_r + ADDR_ONE;
      left_r <= left_r - ADDR_ONE;
    end
  end

  // Completion pulse, one per byte
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      byteDone_r <= 1'b0;
    end else begin
      byteDone_r <= (state_r == ST_TAIL) && cntHit;
    end
  end

  // Link outputs
  assign link.busRequestLineN = busReqN_r;
  assign link.memRd           = memRd_r;
  assign link.memWr           = memWr_r;
  assign link.ioRd            = ioRd_r;
  assign link.ioWr            = ioWr_r;
  assign link.memAddr         = addr_r;
  assign link.dmaData         = data_r;

  // User outputs
  assign byteDone  = byteDone_r;
  assign blockDone = (left_r == ADDR_ZERO);
  assign bytesLeft = left_r;
  assign lastByte  = data_r;
  assign busy      = (state_r != ST_IDLE);
endmodule

// ===== dma_host_end.sv
// Far end: CPU bus arbitration, serial ready line and memory port
module dma_host_end (
  input  wire logic            core_clk,    // System clock
  input  wire logic            sys_rst,     // Synchronous reset, active high
  dma_link_if.host             link,        // Bus and ready lines
  input  wire logic            rxLastBit,   // Pulse: last bit of a character received
  input  wire dma_pkg::data_t  rxChar,      // Received character
  input  wire logic            txLastBit,   // Pulse: last bit of a character sent
  input  wire logic            cpuCycleEnd, // CPU machine cycle ends this period
  input  wire dma_pkg::data_t  memRdData,   // Memory data for DMA reads
  output logic                 memWrStb,    // Pulse: DMA memory write done
  output dma_pkg::addr_t       memWrAddr,   // Address of that write
  output dma_pkg::data_t       memWrData,   // Data of that write
  output logic                 txLoad,      // Pulse: character handed to transmitter
  output dma_pkg::data_t       txChar       // Character to transmit
);
  import dma_pkg::*;

  logic  rxDly_r;
  logic  txDly_r;
  cnt_t  rxCnt_r;
  cnt_t  txCnt_r;
  data_t rxHold_r;
  logic  rxPend_r;
  logic  txPend_r;
  logic  grantN_r;
  logic  cpuWait_r;
  cnt_t  cpuCnt_r;
  data_t hostData_r;
  logic  memWrD_r;
  logic  ioWrD_r;
  logic  memWrStb_r;
  logic  txLoad_r;
  addr_t memWrAddr_r;
  data_t memWrData_r;
  data_t txChar_r;

  // Receive ready delay after the last bit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxDly_r <= 1'b0;
      rxCnt_r <= CNT_ZERO;
    end else if (rxLastBit) begin
      rxDly_r <= 1'b1;
      rxCnt_r <= CNT_ZERO;
    end else if (rxDly_r) begin
      rxDly_r <= (rxCnt_r != RX_RDY_END);  // R03
      rxCnt_r <= rxCnt_r + CNT_ONE;
    end
  end

  // Transmit ready delay after the last bit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txDly_r <= 1'b0;
      txCnt_r <= CNT_ZERO;
    end else if (txLastBit) begin
      txDly_r <= 1'b1;
      txCnt_r <= CNT_ZERO;
    end else if (txDly_r) begin
      txDly_r <= (txCnt_r != TX_RDY_END);  // R08
      txCnt_r <= txCnt_r + CNT_ONE;
    end
  end

  // Held received character
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxHold_r <= DATA_ZERO;
    end else if (rxLastBit) begin
      rxHold_r <= rxChar;
    end
  end

  // Pending service flags; a new request wins over the clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxPend_r <= 1'b0;
      txPend_r <= 1'b0;
    end else begin
      if (rxDly_r && rxCnt_r == RX_RDY_END) begin
        rxPend_r <= 1'b1;  // R01 R03
      end else if (link.ioRd) begin
        rxPend_r <= 1'b0;
      end
      if (txDly_r && txCnt_r == TX_RDY_END) begin
        txPend_r <= 1'b1;  // R01 R08
      end else if (link.ioWr) begin
        txPend_r <= 1'b0;
      end
    end
  end

  // Machine cycle wind-down after a request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpuWait_r <= 1'b0;
      cpuCnt_r  <= CNT_ZERO;
    end else if (!cpuWait_r) begin
      cpuWait_r <= !link.busRequestLineN && grantN_r;
      cpuCnt_r  <= CNT_ZERO;
    end else if ((cpuCycleEnd && cpuCnt_r >= CPU_MIN_END) || cpuCnt_r == CPU_MAX_END) begin
      cpuWait_r <= 1'b0;  // R04
      cpuCnt_r  <= CNT_ZERO;
    end else begin
      cpuCnt_r <= cpuCnt_r + CNT_ONE;
    end
  end

  // Bus grant: one period after the cycle ends, back after the write ends
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      grantN_r <= 1'b1;
    end else if (cpuWait_r && ((cpuCycleEnd && cpuCnt_r >= CPU_MIN_END) || cpuCnt_r == CPU_MAX_END)) begin
      grantN_r <= 1'b0;  // R04
    end else if (!grantN_r && link.busRequestLineN && !link.memWr && !link.ioWr) begin
      grantN_r <= 1'b1;  // R07 R11
    end
  end

  // Read data toward the DMA
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hostData_r <= DATA_ZERO;
    end else begin
      hostData_r <= link.ioRd ? rxHold_r : memRdData;
    end
  end

  // Write completion on the falling strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      memWrD_r    <= 1'b0;
      ioWrD_r     <= 1'b0;
      memWrStb_r  <= 1'b0;
      txLoad_r    <= 1'b0;
      memWrAddr_r <= ADDR_ZERO;
      memWrData_r <= DATA_ZERO;
      txChar_r    <= DATA_ZERO;
    end else begin
      memWrD_r   <= link.memWr;
      ioWrD_r    <= link.ioWr;
      memWrStb_r <= memWrD_r && !link.memWr;
      txLoad_r   <= ioWrD_r && !link.ioWr;
      if (link.memWr) begin
        memWrAddr_r <= link.memAddr;
        memWrData_r <= link.dmaData;
      end
      if (link.ioWr) begin
        txChar_r <= link.dmaData;
      end
    end
  end

  // Link and user outputs
  assign link.readyN        = !(rxPend_r || txPend_r);  // R01
  assign link.busGrantLineN = grantN_r;
  assign link.hostData      = hostData_r;
  assign memWrStb           = memWrStb_r;
  assign memWrAddr          = memWrAddr_r;
  assign memWrData          = memWrData_r;
  assign txLoad             = txLoad_r;
  assign txChar             = txChar_r;
endmodule

// ===== dma_link_props.sv
// Concurrent timing checks on the link between the DMA end and the host end
module dma_link_props (
  input wire logic core_clk,        // System clock
  input wire logic sys_rst,         // Synchronous reset
  input wire logic readyN,          // Ready, active low
  input wire logic busRequestLineN, // Bus request, active low
  input wire logic busGrantLineN,   // Bus grant, active low
  input wire logic memRd,           // Memory read cycle
  input wire logic memWr,           // Memory write cycle
  input wire logic ioRd,            // Serial read cycle
  input wire logic ioWr             // Serial write cycle
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic freshReady_r;

  // Ready seen inactive since the last bus request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      freshReady_r <= 1'b1;
    end else if (!busRequestLineN) begin
      freshReady_r <= 1'b0;
    end else if (readyN) begin
      freshReady_r <= 1'b1;
    end
  end

  // Steps of a transfer
  sequence s_quiet4;
    (!memRd && !ioRd) [*4];
  endsequence
  sequence s_rx_tail;
    ##2 $rose(busRequestLineN) ##1 $fell(memWr);
  endsequence
  sequence s_tx_tail;
    ##3 $rose(busRequestLineN) ##1 $fell(ioWr);
  endsequence

  property p_grant_window;
    $fell(busRequestLineN) |-> ##[2:6] $fell(busGrantLineN);
  endproperty
  property p_grant_hold;
    (!busRequestLineN && !busGrantLineN) |=> !busGrantLineN;
  endproperty
  property p_first_cycle;
    $fell(busGrantLineN) |-> s_quiet4 ##1 ($rose(ioRd) != $rose(memRd));
  endproperty
  property p_rx_gap;
    $rose(ioRd) |-> ioRd [*4] ##1 ($fell(ioRd) && $rose(memWr));
  endproperty
  property p_tx_gap;
    $rose(memRd) |-> memRd [*3] ##1 ($fell(memRd) && $rose(ioWr));
  endproperty
  property p_rx_drop;
    $rose(memWr) |-> s_rx_tail;
  endproperty
  property p_tx_drop;
    $rose(ioWr) |-> s_tx_tail;
  endproperty
  property p_release;
    ($fell(memWr) || $fell(ioWr)) |-> ##1 $rose(busGrantLineN);
  endproperty
  property p_ready_cause;
    $fell(busRequestLineN) |-> !$past(readyN, 2);
  endproperty
  property p_fresh_ready;
    $fell(busRequestLineN) |-> freshReady_r;
  endproperty

  a_grant_window: assert property (p_grant_window) else $error("grant late or missing");
  a_grant_hold: assert property (p_grant_hold) else $error("grant dropped early");
  a_first_cycle: assert property (p_first_cycle) else $error("first cycle mistimed");
  a_rx_gap: assert property (p_rx_gap) else $error("receive read length wrong");
  a_tx_gap: assert property (p_tx_gap) else $error("transmit read length wrong");
  a_rx_drop: assert property (p_rx_drop) else $error("receive request drop mistimed");
  a_tx_drop: assert property (p_tx_drop) else $error("transmit request drop mistimed");
  a_release: assert property (p_release) else $error("grant not withdrawn in time");
  a_ready_cause: assert property (p_ready_cause) else $error("request without ready");
  a_fresh_ready: assert property (p_fresh_ready) else $error("request on stale ready");
endmodule

// ===== dma_serial_byte_transfer_bench.sv
// Self-checking bench joining the DMA end and the host end
module dma_serial_byte_transfer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dma_pkg::*;

  localparam int NUM_BYTES = 3;  // Bytes per block

  logic        core_clk;
  logic        sys_rst;
  logic        enable;
  logic        txMode;
  logic        loadBlock;
  logic        rxLastBit;
  logic        txLastBit;
  logic        cpuCycleEnd;
  logic        blockDone;
  logic        busy;
  logic        byteDone;
  logic        memWrStb;
  logic        txLoad;
  addr_t       startAddr;
  addr_t       blockLen;
  addr_t       bytesLeft;
  addr_t       memWrAddr;
  data_t       rxChar;
  data_t       memRdData;
  data_t       lastByte;
  data_t       memWrData;
  data_t       txChar;
  logic [24:0] expQ[$];
  int          num_errors = 0;
  int          compares = 0;
  int          doneCnt = 0;

  dma_link_if u_dma_link_if ();

  dma_byte_engine u_dma_byte_engine (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(u_dma_link_if), .enable(enable),
    .txMode(txMode), .loadBlock(loadBlock), .startAddr(startAddr), .blockLen(blockLen),
    .byteDone(byteDone), .blockDone(blockDone), .bytesLeft(bytesLeft), .lastByte(lastByte), .busy(busy)
  );

  dma_host_end u_dma_host_end (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(u_dma_link_if), .rxLastBit(rxLastBit),
    .rxChar(rxChar), .txLastBit(txLastBit), .cpuCycleEnd(cpuCycleEnd), .memRdData(memRdData),
    .memWrStb(memWrStb), .memWrAddr(memWrAddr), .memWrData(memWrData), .txLoad(txLoad),
    .txChar(txChar)
  );

  dma_link_props u_dma_link_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .readyN(u_dma_link_if.readyN),
    .busRequestLineN(u_dma_link_if.busRequestLineN), .busGrantLineN(u_dma_link_if.busGrantLineN),
    .memRd(u_dma_link_if.memRd), .memWr(u_dma_link_if.memWr), .ioRd(u_dma_link_if.ioRd),
    .ioWr(u_dma_link_if.ioWr)
  );

  // Clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One cycle; CPU cycle end is random each period
  task automatic tick();
    @(posedge core_clk);
    #2;
    cpuCycleEnd = 1'($urandom_range(1, 0));
  endtask

  // Last-bit strobe, then cycles until ready goes active
  task automatic send_char(input logic isTx, input int lo, input int hi);
    int n;
    n = 0;
    rxLastBit = ~isTx;
    txLastBit = isTx;
    tick();
    rxLastBit = 1'b0;
    txLastBit = 1'b0;
    while (u_dma_link_if.readyN !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask

  // Wait until every noted result has appeared and the engine is idle
  task automatic wait_drain();
    int n;
    n = 0;
    while ((expQ.size() != 0 || busy !== 1'b0) && n < 100) begin
      tick();
      n++;
    end
    check(32'(n < 100), 32'h1);
  endtask

  task automatic load_block(input logic mode, input addr_t addr);
    txMode = mode;
    startAddr = addr;
    blockLen = 16'(NUM_BYTES);
    loadBlock = 1'b1;
    tick();
    loadBlock = 1'b0;
    tick();
  endtask

  // Result watcher: oldest note against each write or transmit load
  always @(posedge core_clk) begin
    if (memWrStb === 1'b1 || txLoad === 1'b1) begin
      if (expQ.size() == 0)
        check(32'h0, 32'hFFFFFFFF);
      else if (txLoad === 1'b1)
        check(32'({1'b1, 16'h0000, txChar}), 32'(expQ.pop_front()));
      else
        check(32'({1'b0, memWrAddr, memWrData}), 32'(expQ.pop_front()));
    end
  end

  // Completion pulses, one per byte moved
  always @(posedge core_clk) begin
    if (byteDone === 1'b1)
      doneCnt++;
  end

  // Watchdog
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    addr_t addr;
    addr_t txAddr;
    data_t ch;
    int    reqSeen;
    {enable, txMode, loadBlock, rxLastBit, txLastBit, cpuCycleEnd} = 6'h00;
    startAddr = 16'h0000;
    blockLen = 16'h0000;
    rxChar = 8'h00;
    memRdData = 8'h00;
    sys_rst = 1'b1;
    void'($urandom(32'hA06F6990));
    repeat (12) tick();
    sys_rst = 1'b0;
    // Receive block; the first byte waits behind a low enable
    addr = 16'($urandom);
    load_block(1'b0, addr);
    for (int i = 0; i < NUM_BYTES; i++) begin
      ch = 8'($urandom);
      rxChar = ch;
      expQ.push_back({1'b0, addr + 16'(i), ch});
      send_char(1'b0, 10, 13);
      if (i == 0) begin
        repeat (40) tick();
        check(32'(expQ.size()), 32'h1);
        enable = 1'b1;
      end
      wait_drain();
    end
    check(32'(bytesLeft), 32'h0);
    check(32'(blockDone), 32'h1);
    check(32'(lastByte), 32'(ch));
    // Transmit block, memory data held per byte
    txAddr = 16'($urandom);
    load_block(1'b1, txAddr);
    for (int i = 0; i < NUM_BYTES; i++) begin
      ch = 8'($urandom);
      memRdData = ch;
      expQ.push_back({1'b1, 16'h0000, ch});
      send_char(1'b1, 5, 6);
      wait_drain();
      check(32'(u_dma_link_if.memAddr), 32'(txAddr + 16'(i + 1)));
    end
    check(32'(lastByte), 32'(ch));
    // Ready with the block used up must not win the bus
    reqSeen = 0;
    send_char(1'b0, 10, 13);
    repeat (40) begin
      tick();
      if (u_dma_link_if.busRequestLineN !== 1'b1)
        reqSeen++;
    end
    check(32'(reqSeen), 32'h0);
    check(32'(doneCnt), 32'(2 * NUM_BYTES));
    tally_and_finish();
  end
endmodule
